/* File: rtl/rtd_ring_trip.sv */
// Ring trip detector with low-pass filter, threshold, debounce and interrupt block.
// Assumes register strobes and monitor samples come from logic on clk_i.
//
// Contract
// R1: Detector input is the loop current value, also readable at offset 79.
// R2: Samples are processed only while the linefeed shadow shows ringing.
// R3: Writing linefeed field value 100 binary selects the ringing state.
// R4: Low-pass filter uses a 13-bit programmable coefficient before comparison.
// R5: Filter output compared against six-bit threshold in indirect register 16.
// R6: Debounced state flips only after the opposite state lasts the interval.
// R7: Debounce count restarts when comparator agrees again before interval ends.
// R8: Satisfied debounce sets the trip detected flag in register 68.
// R9: Trip detected flag is read only; writes do not change it.
// R10: Ring trip interrupt only when its enable bit in register 22 set.
// R11: Pending ring trip interrupt is shown in status register 19.
// R12: Software picks coefficient, threshold and debounce per ringing frequency.
// R13: Coefficient and threshold live in indirect registers via registers 28-31.
// R14: Three status and three enable registers, one bit per source.
// R15: Enable bits are active high.
// R16: Status bit sets on an event only when its enable is set.
// R17: Interrupt pin low as NOR of all status bits while any set.
// R18: Writing one clears a status bit; writing zero leaves it.
// R19: Host reads the status registers to find the requesting source.
`timescale 1ns/100ps
`default_nettype none

module rtd_ring_trip (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic [6:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_wdata_i,
	output logic [7:0] reg_rdata_o,
	input wire logic sample_valid_i,
	input wire logic [5:0] loop_current_value_i,
	input wire logic loop_current_pol_i,
	input wire logic [7:0] evt_s1_i,
	input wire logic [7:0] evt_s2_i,
	input wire logic [2:0] evt_s3_i,
	output logic [2:0] linefeed_state_field_o,
	output logic trip_detected_flag_o,
	output logic int_n_o
);
	import rtd_pkg::*;

	// ==========================================================
	// State
	typedef struct packed {
		logic [2:0] lf;
		logic [2:0] lfs;
		logic [6:0] debounce;
		logic [7:0] ie1;
		logic [7:0] ie2;
		logic [2:0] ie3;
		logic [7:0] is1;
		logic [7:0] is2;
		logic [2:0] is3;
		logic [15:0] ind_data;
		logic [7:0] ind_addr;
		logic ind_armed;
		logic [15:0] threshold;
		logic [12:0] coeff;
		logic [15:0] filt;
		logic trip_flag;
		logic [6:0] cnt;
		logic [7:0] rdata;
		logic irq_n;
	} rtd_state_t;

	rtd_state_t state_reg;
	rtd_state_t state_next;

	logic ringing;
	logic cmp;
	logic trip_evt;
	logic ind_done;
	logic [15:0] x_scaled;
	logic signed [16:0] diff;
	logic signed [30:0] prod;
	logic [17:0] filt_sum;
	logic [7:0] ev2;
	logic [2:0] ev3;
	logic [7:0] rd_mux;

	// ==========================================================
	// Next-state logic
	always_comb begin
		state_next = state_reg;
		ringing = (state_reg.lfs == LINEFEED_RINGING); // [R2]
		x_scaled = {loop_current_value_i, 10'h000}; // [R1]
		diff = $signed({1'b0, x_scaled}) - $signed({1'b0, state_reg.filt});
		prod = diff * $signed({1'b0, state_reg.coeff}); // [R4]
		filt_sum = {2'b00, state_reg.filt} + prod[30:COEFF_FRAC_BITS];
		// Threshold kept in current units so the field aligns with the filter's top bits
		cmp = (state_reg.filt >= {state_reg.threshold[THRESHOLD_LSB +: 6], 10'h000}); // [R5]
		trip_evt = 1'b0;
		ind_done = 1'b0;
		rd_mux = 8'h00;

		// Shadow trails the control field by one cycle
		state_next.lfs = state_reg.lf;

		// Filter and debounce advance per monitor sample, only while ringing
		if (sample_valid_i && ringing) begin // [R2]
			state_next.filt = filt_sum[15:0]; // [R4]
			if (cmp != state_reg.trip_flag) begin
				if ({1'b0, state_reg.cnt} + 8'h01 >= {1'b0, state_reg.debounce}) begin // [R6]
					state_next.trip_flag = cmp; // [R8]
					state_next.cnt = 7'h00;
					trip_evt = cmp;
				end else begin
					state_next.cnt = state_reg.cnt + 7'h01;
				end
			end else begin
				state_next.cnt = 7'h00; // [R7]
			end
		end

		// Register writes; status registers are write-one-to-clear
		if (reg_wr_i) begin
			case (reg_addr_i)
				IRQ_STATUS_ONE_OFS: state_next.is1 = state_reg.is1 & ~reg_wdata_i; // [R18]
				IRQ_STATUS_TWO_OFS: state_next.is2 = state_reg.is2 & ~reg_wdata_i; // [R18]
				IRQ_STATUS_THREE_OFS: state_next.is3 = state_reg.is3 & ~reg_wdata_i[2:0]; // [R18]
				IRQ_ENABLE_ONE_OFS: state_next.ie1 = reg_wdata_i;
				IRQ_ENABLE_TWO_OFS: state_next.ie2 = reg_wdata_i; // [R10]
				IRQ_ENABLE_THREE_OFS: state_next.ie3 = reg_wdata_i[2:0];
				IND_DATA_LOW_OFS: begin
					state_next.ind_data[7:0] = reg_wdata_i;
					state_next.ind_armed = 1'b1;
				end
				IND_DATA_HIGH_OFS: begin
					state_next.ind_data[15:8] = reg_wdata_i;
					state_next.ind_armed = 1'b1;
				end
				IND_ADDR_OFS: begin
					// Armed data means an indirect write, otherwise an indirect read
					state_next.ind_addr = reg_wdata_i;
					state_next.ind_armed = 1'b0;
					ind_done = 1'b1;
					if (state_reg.ind_armed) begin // [R13]
						if (reg_wdata_i == TRIP_THRESHOLD_IDX) begin
							state_next.threshold = state_reg.ind_data;
						end else if (reg_wdata_i == TRIP_FILTER_COEFF_IDX) begin
							state_next.coeff = state_reg.ind_data[12:0];
						end
					end else begin
						if (reg_wdata_i == TRIP_THRESHOLD_IDX) begin
							state_next.ind_data = state_reg.threshold;
						end else if (reg_wdata_i == TRIP_FILTER_COEFF_IDX) begin
							state_next.ind_data = {3'h0, state_reg.coeff};
						end else begin
							state_next.ind_data = 16'h0000;
						end
					end
				end
				LINEFEED_CTRL_OFS: state_next.lf = reg_wdata_i[2:0]; // [R3]
				TRIP_DEBOUNCE_OFS: state_next.debounce = reg_wdata_i[6:0];
				default: begin
					// Status register 68 and sense register 79 ignore writes
				end
			endcase
		end

		// Events set status when enabled; a set beats a same-cycle clear
		ev2 = evt_s2_i | {7'h00, trip_evt}; // [R10]
		ev3 = evt_s3_i | {1'b0, ind_done, 1'b0};
		state_next.is1 = state_next.is1 | (evt_s1_i & state_reg.ie1); // [R16]
		state_next.is2 = state_next.is2 | (ev2 & state_reg.ie2); // [R11] [R15] [R16]
		state_next.is3 = state_next.is3 | (ev3 & state_reg.ie3); // [R14] [R16]
		state_next.irq_n = ~(|{state_next.is1, state_next.is2, state_next.is3}); // [R17]

		// Read data is registered; unmapped offsets read zero
		case (reg_addr_i)
			IRQ_STATUS_ONE_OFS: rd_mux = state_reg.is1;
			IRQ_STATUS_TWO_OFS: rd_mux = state_reg.is2; // [R11]
			IRQ_STATUS_THREE_OFS: rd_mux = {5'h00, state_reg.is3};
			IRQ_ENABLE_ONE_OFS: rd_mux = state_reg.ie1;
			IRQ_ENABLE_TWO_OFS: rd_mux = state_reg.ie2;
			IRQ_ENABLE_THREE_OFS: rd_mux = {5'h00, state_reg.ie3};
			IND_DATA_LOW_OFS: rd_mux = state_reg.ind_data[7:0];
			IND_DATA_HIGH_OFS: rd_mux = state_reg.ind_data[15:8];
			IND_ADDR_OFS: rd_mux = state_reg.ind_addr;
			IND_STATUS_OFS: rd_mux = 8'h00; // Indirect access completes in one cycle
			LINEFEED_CTRL_OFS: rd_mux = {1'b0, state_reg.lfs, 1'b0, state_reg.lf};
			LOOP_RING_STATUS_OFS: rd_mux = {6'h00, state_reg.trip_flag, 1'b0}; // [R9]
			TRIP_DEBOUNCE_OFS: rd_mux = {1'b0, state_reg.debounce};
			LOOP_CURRENT_SENSE_OFS: rd_mux = {1'b0, loop_current_pol_i, loop_current_value_i}; // [R1]
			default: rd_mux = 8'h00;
		endcase
		if (reg_rd_i) begin
			state_next.rdata = rd_mux;
		end
	end

	// ==========================================================
	// State register
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			state_reg <= '0;
			state_reg.debounce <= TRIP_DEBOUNCE_RST;
			state_reg.threshold <= TRIP_THRESHOLD_RST;
			state_reg.coeff <= TRIP_FILTER_COEFF_RST;
			state_reg.irq_n <= 1'b1;
		end else begin
			state_reg <= state_next;
		end
	end

	// Outputs straight from the state flops
	assign reg_rdata_o = state_reg.rdata;
	assign linefeed_state_field_o = state_reg.lfs;
	assign trip_detected_flag_o = state_reg.trip_flag;
	assign int_n_o = state_reg.irq_n;

	// ==========================================================
	// Assertions
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (sys_rst_i);

	// Pin low exactly when any status bit is pending
	a_irq_pin_nor: assert property (int_n_o == !(|{state_reg.is1, state_reg.is2, state_reg.is3})) // [R17]
		else $error("interrupt pin does not match status NOR");

	// Write one clears a bit whose source is quiet
	a_status_w1c: assert property ((reg_wr_i && reg_addr_i == IRQ_STATUS_TWO_OFS && reg_wdata_i[2] // [R18]
		&& !evt_s2_i[2]) |=> !state_reg.is2[2] && int_n_o == !(|{state_reg.is1, state_reg.is2, state_reg.is3}))
		else $error("status bit not cleared by write of one");

	// Write zero keeps a pending bit
	a_status_w0_keep: assert property ((reg_wr_i && reg_addr_i == IRQ_STATUS_TWO_OFS && !reg_wdata_i[0] // [R18]
		&& state_reg.is2[0]) |=> state_reg.is2[0])
		else $error("status bit lost on write of zero");

	// Trip status rises only with its enable set
	a_trip_irq_gated: assert property ($rose(state_reg.is2[TRIP_IRQ_BIT]) |-> $past(state_reg.ie2[TRIP_IRQ_BIT])) // [R10] [R16]
		else $error("trip status set while disabled");

	// Enabled trip posts to status register 19 with the flag
	a_trip_irq_post: assert property (($rose(state_reg.trip_flag) && $past(state_reg.ie2[TRIP_IRQ_BIT])) // [R8] [R11]
		|-> state_reg.is2[TRIP_IRQ_BIT] && !int_n_o)
		else $error("enabled trip did not post interrupt");

	// Filter frozen outside the ringing state
	a_filter_ring_only: assert property ((state_reg.lfs != LINEFEED_RINGING) |=> $stable(state_reg.filt) // [R2]
		&& $stable(state_reg.trip_flag))
		else $error("filter moved outside ringing");

	// Flag never moved by a register write
	a_flag_read_only: assert property ((reg_wr_i && reg_addr_i == LOOP_RING_STATUS_OFS && !sample_valid_i) // [R9]
		|=> $stable(state_reg.trip_flag))
		else $error("trip flag changed by write");

	// Flag flips only after the full interval
	a_debounce_hold: assert property ($changed(state_reg.trip_flag) // [R6]
		|-> ({1'b0, $past(state_reg.cnt)} + 8'h01 >= {1'b0, $past(state_reg.debounce)}))
		else $error("debounced state changed early");

	// Agreement restarts the interval count
	a_debounce_restart: assert property ((sample_valid_i && ringing && cmp == state_reg.trip_flag) // [R7]
		|=> state_reg.cnt == 7'h00)
		else $error("debounce count not restarted");

	// Ringing code reaches the shadow two cycles later
	a_ringing_entry: assert property ((reg_wr_i && reg_addr_i == LINEFEED_CTRL_OFS // [R3]
		&& reg_wdata_i[2:0] == LINEFEED_RINGING) |=> ##1 state_reg.lfs == $past(state_reg.lf)
		&& $past(state_reg.lf) == LINEFEED_RINGING)
		else $error("ringing state not entered");

	// Sense register mirrors the live current inputs
	a_sense_readback: assert property ((reg_rd_i && reg_addr_i == LOOP_CURRENT_SENSE_OFS) // [R1]
		|=> reg_rdata_o == {1'b0, $past(loop_current_pol_i), $past(loop_current_value_i)})
		else $error("current sense readback wrong");

	// Filter never moves away from a higher input
	a_filter_rises: assert property ((sample_valid_i && ringing && x_scaled > state_reg.filt) // [R4]
		|=> state_reg.filt >= $past(state_reg.filt))
		else $error("filter fell on higher input");

	// Filter never moves away from a lower input
	a_filter_falls: assert property ((sample_valid_i && ringing && x_scaled < state_reg.filt) // [R4]
		|=> state_reg.filt <= $past(state_reg.filt))
		else $error("filter rose on lower input");

	// Filter below the threshold field never trips the comparator
	a_cmp_below: assert property ((state_reg.filt[15:10] < state_reg.threshold[THRESHOLD_LSB +: 6]) // [R5]
		|-> !cmp)
		else $error("comparator high below threshold");

	// Armed index write loads the threshold
	a_ind_thr_write: assert property ((reg_wr_i && reg_addr_i == IND_ADDR_OFS && state_reg.ind_armed // [R13]
		&& reg_wdata_i == TRIP_THRESHOLD_IDX) |=> state_reg.threshold == $past(state_reg.ind_data))
		else $error("indirect threshold write lost");

	// Unarmed index write fetches the threshold
	a_ind_thr_read: assert property ((reg_wr_i && reg_addr_i == IND_ADDR_OFS && !state_reg.ind_armed // [R13]
		&& reg_wdata_i == TRIP_THRESHOLD_IDX) |=> state_reg.ind_data == $past(state_reg.threshold))
		else $error("indirect threshold read wrong");

	// Armed index write loads the filter coefficient
	a_coeff_write: assert property ((reg_wr_i && reg_addr_i == IND_ADDR_OFS && state_reg.ind_armed // [R4] [R13]
		&& reg_wdata_i == TRIP_FILTER_COEFF_IDX) |=> state_reg.coeff == $past(state_reg.ind_data[12:0]))
		else $error("indirect coefficient write lost");

	// Disagreement short of the interval only counts
	a_debounce_wait: assert property ((sample_valid_i && ringing && cmp != state_reg.trip_flag // [R6]
		&& ({1'b0, state_reg.cnt} + 8'h01 < {1'b0, state_reg.debounce})) |=> $stable(state_reg.trip_flag))
		else $error("debounce did not wait");

	// Interval met on a high comparator sets the flag
	a_trip_sets_flag: assert property ((sample_valid_i && ringing && cmp && !state_reg.trip_flag // [R8]
		&& ({1'b0, state_reg.cnt} + 8'h01 >= {1'b0, state_reg.debounce})) |=> state_reg.trip_flag)
		else $error("trip flag not set");

	// Interval count frozen outside ringing
	a_count_frozen: assert property (!ringing // [R2]
		|=> $stable(state_reg.cnt))
		else $error("debounce count moved outside ringing");

	// Enabled event on status register one posts
	a_status1_post: assert property ((evt_s1_i[2] && state_reg.ie1[2]) // [R14] [R16]
		|=> state_reg.is1[2])
		else $error("status one event lost");

	// Enabled event on status register three posts
	a_status3_post: assert property ((evt_s3_i[2] && state_reg.ie3[2]) // [R14] [R16]
		|=> state_reg.is3[2])
		else $error("status three event lost");

	// Clear enable keeps a quiet bit clear
	a_enable_blocks: assert property ((!state_reg.ie1[2] && !state_reg.is1[2] && !reg_wr_i) // [R15] [R16]
		|=> !state_reg.is1[2])
		else $error("disabled event posted");

	// Read data stands between reads
	a_rdata_stands: assert property (!reg_rd_i // [R11]
		|=> $stable(reg_rdata_o))
		else $error("read data changed without read");

endmodule : rtd_ring_trip

`default_nettype wire

/* File: rtl/rtd_pkg.sv */
// Package for the ring trip detector and the shared interrupt logic.
// Assumes a 7-bit register address, 8-bit register data and one system clock.
package rtd_pkg;

	// ==========================================================
	// Direct register offsets
	localparam logic [6:0] IRQ_STATUS_ONE_OFS = 7'h12;
	localparam logic [6:0] IRQ_STATUS_TWO_OFS = 7'h13;
	localparam logic [6:0] IRQ_STATUS_THREE_OFS = 7'h14;
	localparam logic [6:0] IRQ_ENABLE_ONE_OFS = 7'h15;
	localparam logic [6:0] IRQ_ENABLE_TWO_OFS = 7'h16;
	localparam logic [6:0] IRQ_ENABLE_THREE_OFS = 7'h17;
	localparam logic [6:0] IND_DATA_LOW_OFS = 7'h1c;
	localparam logic [6:0] IND_DATA_HIGH_OFS = 7'h1d;
	localparam logic [6:0] IND_ADDR_OFS = 7'h1e;
	localparam logic [6:0] IND_STATUS_OFS = 7'h1f;
	localparam logic [6:0] LINEFEED_CTRL_OFS = 7'h40;
	localparam logic [6:0] LOOP_RING_STATUS_OFS = 7'h44;
	localparam logic [6:0] TRIP_DEBOUNCE_OFS = 7'h46;
	localparam logic [6:0] LOOP_CURRENT_SENSE_OFS = 7'h4f;

	// ==========================================================
	// Indirect register indices
	localparam logic [7:0] TRIP_THRESHOLD_IDX = 8'h10;
	localparam logic [7:0] TRIP_FILTER_COEFF_IDX = 8'h17;

	// ==========================================================
	// Field positions and encodings
	localparam logic [2:0] LINEFEED_RINGING = 3'h4;
	localparam int LINEFEED_SHADOW_LSB = 4;
	localparam int TRIP_FLAG_BIT = 1;
	localparam int TRIP_IRQ_BIT = 0;
	localparam int IND_DONE_IRQ_BIT = 1;
	localparam int THRESHOLD_LSB = 10;
	localparam int CURRENT_SCALE_SHIFT = 10;
	localparam int COEFF_FRAC_BITS = 13;

	// ==========================================================
	// Values after reset
	localparam logic [15:0] TRIP_THRESHOLD_RST = 16'h0000;
	localparam logic [12:0] TRIP_FILTER_COEFF_RST = 13'h0000;
	localparam logic [6:0] TRIP_DEBOUNCE_RST = 7'h00;

endpackage : rtd_pkg

/* File: testbench/test_ring_trip_detect_irq.sv */
// Self-checking bench for the ring trip detector and interrupt block.
// Assumes the block's own register strobes; inputs change by NBA at posedge.
`timescale 1ns/100ps
`default_nettype none

module test_ring_trip_detect_irq;
	import rtd_pkg::*;
	logic clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic [6:0] reg_addr_i = 7'h00;
	logic reg_wr_i = 1'b0;
	logic reg_rd_i = 1'b0;
	logic [7:0] reg_wdata_i = 8'h00;
	logic [7:0] reg_rdata_o;
	logic sample_valid_i = 1'b0;
	logic [5:0] loop_current_value_i = 6'h00;
	logic loop_current_pol_i = 1'b0;
	logic [7:0] evt_s1_i = 8'h00;
	logic [7:0] evt_s2_i = 8'h00;
	logic [2:0] evt_s3_i = 3'h0;
	logic [2:0] linefeed_state_field_o;
	logic trip_detected_flag_o;
	logic int_n_o;
	int num_errors = 0;
	int checks_done = 0;

	rtd_ring_trip dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
		.reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
		.sample_valid_i(sample_valid_i), .loop_current_value_i(loop_current_value_i),
		.loop_current_pol_i(loop_current_pol_i), .evt_s1_i(evt_s1_i), .evt_s2_i(evt_s2_i),
		.evt_s3_i(evt_s3_i), .linefeed_state_field_o(linefeed_state_field_o),
		.trip_detected_flag_o(trip_detected_flag_o), .int_n_o(int_n_o));

	// ==========================================================
	// Clock and shared tasks
	always #5 clk_i = ~clk_i;

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		@(posedge clk_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge clk_i);
		reg_wr_i <= 1'b0;
	endtask : wr

	// Data stands until the next read, so sampling one edge late is safe
	task automatic rd(input logic [6:0] a, input logic [7:0] exp);
		@(posedge clk_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge clk_i);
		reg_rd_i <= 1'b0;
		@(posedge clk_i);
		#1 chk(reg_rdata_o, exp);
	endtask : rd

	// One current sample every four cycles, n times
	task automatic smp(input logic [5:0] v, input int n);
		repeat (n) begin
			@(posedge clk_i);
			loop_current_value_i <= v;
			sample_valid_i <= 1'b1;
			@(posedge clk_i);
			sample_valid_i <= 1'b0;
			repeat (2) @(posedge clk_i);
		end
	endtask : smp

	task automatic ind_wr(input logic [7:0] idx, input logic [15:0] d);
		wr(IND_DATA_LOW_OFS, d[7:0]);
		wr(IND_DATA_HIGH_OFS, d[15:8]);
		wr(IND_ADDR_OFS, idx);
	endtask : ind_wr

	task automatic results;
		$display("checks=%0d errors=%0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : results

	// Watchdog, counts as a mismatch
	initial begin
		#500us;
		num_errors++;
		results();
	end

	// ==========================================================
	// Main sequence
	initial begin
		logic [6:0] sa;
		repeat (4) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		@(posedge clk_i);
		#1 chk({7'h0, int_n_o}, 8'h01);
		rd(IRQ_STATUS_TWO_OFS, 8'h00);
		rd(7'h7f, 8'h00);
		loop_current_pol_i <= 1'b1;
		smp(6'h2a, 1);
		rd(LOOP_CURRENT_SENSE_OFS, 8'h6a);
		smp(6'h3f, 8);
		chk({7'h0, trip_detected_flag_o}, 8'h00);
		$display("test reset and idle done");
		// Fast filter, threshold 8 steps, three-sample debounce
		wr(TRIP_DEBOUNCE_OFS, 8'h03);
		ind_wr(TRIP_THRESHOLD_IDX, 16'h2000);
		ind_wr(TRIP_FILTER_COEFF_IDX, 16'h1fff);
		wr(IND_ADDR_OFS, TRIP_THRESHOLD_IDX);
		rd(IND_DATA_HIGH_OFS, 8'h20);
		wr(IRQ_ENABLE_TWO_OFS, 8'h01);
		rd(IRQ_ENABLE_TWO_OFS, 8'h01);
		wr(LINEFEED_CTRL_OFS, 8'h04);
		repeat (3) @(posedge clk_i);
		#1 chk({5'h0, linefeed_state_field_o}, 8'h04);
		smp(6'h3f, 2);
		chk({7'h0, trip_detected_flag_o}, 8'h00);
		smp(6'h00, 2);
		smp(6'h3f, 2);
		chk({7'h0, trip_detected_flag_o}, 8'h00);
		smp(6'h3f, 4);
		chk({7'h0, trip_detected_flag_o}, 8'h01);
		chk({7'h0, int_n_o}, 8'h00);
		rd(IRQ_STATUS_TWO_OFS, 8'h01);
		rd(LOOP_RING_STATUS_OFS, 8'h02);
		wr(LOOP_RING_STATUS_OFS, 8'h00);
		rd(LOOP_RING_STATUS_OFS, 8'h02);
		wr(IRQ_STATUS_TWO_OFS, 8'h00);
		rd(IRQ_STATUS_TWO_OFS, 8'h01);
		wr(IRQ_STATUS_TWO_OFS, 8'h01);
		rd(IRQ_STATUS_TWO_OFS, 8'h00);
		chk({7'h0, int_n_o}, 8'h01);
		$display("test trip with interrupt done");
		// Second trip with the enable off must stay silent
		smp(6'h00, 6);
		chk({7'h0, trip_detected_flag_o}, 8'h00);
		wr(IRQ_ENABLE_TWO_OFS, 8'h00);
		smp(6'h3f, 6);
		chk({7'h0, trip_detected_flag_o}, 8'h01);
		rd(IRQ_STATUS_TWO_OFS, 8'h00);
		chk({7'h0, int_n_o}, 8'h01);
		$display("test masked trip done");
		// Each status register: dropped while disabled, posted when enabled
		for (int i = 0; i < 3; i++) begin
			sa = 7'h12 + 7'(i);
			for (int e = 0; e < 2; e++) begin
				wr(7'h15 + 7'(i), e ? 8'h04 : 8'h00);
				@(posedge clk_i);
				evt_s1_i <= (i == 0) ? 8'h04 : 8'h00;
				evt_s2_i <= (i == 1) ? 8'h04 : 8'h00;
				evt_s3_i <= (i == 2) ? 3'h4 : 3'h0;
				@(posedge clk_i);
				evt_s1_i <= 8'h00;
				evt_s2_i <= 8'h00;
				evt_s3_i <= 3'h0;
				rd(sa, e ? 8'h04 : 8'h00);
				chk({7'h0, int_n_o}, e ? 8'h00 : 8'h01);
			end
			wr(sa, 8'h04);
			rd(sa, 8'h00);
		end
		$display("test status registers done");
		// Recommended 20 Hz settings read back intact
		ind_wr(TRIP_FILTER_COEFF_IDX, 16'h0320);
		ind_wr(TRIP_THRESHOLD_IDX, 16'h3600);
		wr(TRIP_DEBOUNCE_OFS, 8'h0b);
		wr(IND_ADDR_OFS, TRIP_FILTER_COEFF_IDX);
		rd(IND_DATA_HIGH_OFS, 8'h03);
		rd(IND_DATA_LOW_OFS, 8'h20);
		wr(IND_ADDR_OFS, TRIP_THRESHOLD_IDX);
		rd(IND_DATA_HIGH_OFS, 8'h36);
		rd(TRIP_DEBOUNCE_OFS, 8'h0b);
		$display("test recommended settings done");
		results();
	end
endmodule : test_ring_trip_detect_irq

`default_nettype wire
